/* File: rtl/rcr_regs.svh */
// Register offsets, field positions, reset values and timing of the recorder.
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RCR_ADDR_W 12
`define RCR_OFS_CAUSE 12'hff0
`define RCR_OFS_IRQ_STATUS 12'hff4
`define RCR_OFS_IRQ_MASK 12'hff8

// ****************************************************************
// Cause register fields
// ****************************************************************
`define RCR_BIT_POWER_UP 7
`define RCR_BIT_SLEEP_RECOVERY 6
`define RCR_BIT_WATCHDOG 5
`define RCR_BIT_PIN_RESET 4
`define RCR_FLAGS_LSB 4
`define RCR_CAUSE_W 8
`define RCR_FLAGS_RESET 4'h8
`define RCR_FLAGS_POWER 4'h8
`define RCR_FLAGS_GPIO_WAKE 4'h4
`define RCR_FLAGS_WDT_WAKE 4'h6

// ****************************************************************
// Interrupt status bits, one per reset source
// ****************************************************************
`define RCR_IRQ_W 7
`define RCR_IRQ_POWER_ON 0
`define RCR_IRQ_BROWNOUT 1
`define RCR_IRQ_WATCHDOG 2
`define RCR_IRQ_GPIO_WAKE 3
`define RCR_IRQ_DEBUG_WAKE 4
`define RCR_IRQ_DEBUGGER 5
`define RCR_IRQ_PIN 6
`define RCR_IRQ_RESET 7'h00

// ****************************************************************
// Timing
// ****************************************************************
`define RCR_CLK_MHZ 25
`define RCR_RESET_HOLD_NS 1000
`define RCR_RESET_HOLD_CYCLES ((`RCR_RESET_HOLD_NS * `RCR_CLK_MHZ + 999) / 1000)
`define RCR_PIN_FILTER_NS 120
`define RCR_PIN_FILTER_CYCLES ((`RCR_PIN_FILTER_NS * `RCR_CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/rcr_pkg.sv */
// Types shared by the reset cause recorder.
package rcr_pkg;

  // Reset and wake sources, each a one-cycle pulse.
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic wdt_timeout;
    logic gpio_wake;
    logic debug_wake;
    logic debugger_reset;
  } rcr_events_t;

  typedef enum logic [1:0] {
    RCR_IDLE,
    RCR_HOLD_INT,
    RCR_HOLD_EXT
  } rcr_state_t;

endpackage

/* File: rtl/rcr_pin_filter.sv */
// Filter that turns a stable low level on the reset pin into one pulse.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_regs.svh"
module rcr_pin_filter #(
  parameter int FILTER_CYCLES = `RCR_PIN_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pin sense
  input wire logic pin_n,
  input wire logic ignore,
  // Result
  output logic assert_pulse
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);

  generate
    if (FILTER_CYCLES < 1) begin : g_bad
      $error("rcr_pin_filter: FILTER_CYCLES must be at least 1");
    end
  endgenerate

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic fired_q;
  logic fired_d;
  logic pulse_q;
  wire low_seen = !pin_n && !ignore;
  wire reach = (cnt_q == CW'(FILTER_CYCLES - 1)) && low_seen && !fired_q;

  // A low is counted only while the device itself is not driving the pin,
  // so our own indication can never be mistaken for an outside reset.
  assign cnt_d = !low_seen ? '0 : (reach || fired_q) ? cnt_q : cnt_q + 1'b1;
  assign fired_d = low_seen ? (fired_q || reach) : 1'b0;
  assign assert_pulse = pulse_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fired_q <= fired_d;
      pulse_q <= reach;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rcr_top.sv */
// Reset cause recorder with APB registers, reset pin and interrupt.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_regs.svh"

// Overview of operation
// - Any of seven sources starts device reset.
// - Reset pin both senses and signals reset.
// - Power flag set on power-on, cleared by pin wake and any watchdog timeout.
// - Reading cause register clears bits 7 to 4.
// - Sleep recovery flag set on pin and watchdog wakes.
// - Sleep flag cleared by power-on or awake watchdog.
// - Watchdog flag set on every watchdog timeout.
// - Watchdog flag cleared by power-on, pin wake.
// - Pin flag set by external pin reset.
// - Pin flag cleared by power-on, pin wake, watchdog wake.
// - Debugger reset leaves power-on flag pattern.
// - Debug pin wake leaves power-on flag pattern.
// - Pin wake gives sleep flag only.
// - Watchdog wake sets sleep and watchdog flags.
module rcr_top #(
  parameter int RESET_HOLD_CYCLES = `RCR_RESET_HOLD_CYCLES,
  parameter int PIN_FILTER_CYCLES = `RCR_PIN_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset and wake sources
  input wire rcr_pkg::rcr_events_t events,
  input wire logic in_sleep,
  // Bidirectional reset pin, active low
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe,
  // Results
  output logic sys_reset_out,
  output logic irq
);
  localparam int HW = $clog2(RESET_HOLD_CYCLES + 1);

  generate
    if (RESET_HOLD_CYCLES < 1) begin : g_bad_hold
      $error("rcr_top: RESET_HOLD_CYCLES must be at least 1");
    end
    if (PIN_FILTER_CYCLES < 1) begin : g_bad_filter
      $error("rcr_top: PIN_FILTER_CYCLES must be at least 1");
    end
  endgenerate

  // ****************************************************************
  // Source decode
  // ****************************************************************

  // Wake requests count only while the device sleeps, and in_sleep is
  // taken in the same cycle as the pulse. An awake gpio or debug pulse is
  // refused here so that it can neither start a reset nor touch a flag.
  wire gpio_wake_ok = events.gpio_wake && in_sleep;
  wire debug_wake_ok = events.debug_wake && in_sleep;
  wire wdt_wake = events.wdt_timeout && in_sleep;
  wire power_like = events.power_on || events.brownout ||
    events.debugger_reset;

  // ****************************************************************
  // Flag update
  // ****************************************************************

  // Later steps override earlier ones, so the power-like causes win when
  // several sources land in the same cycle.
  function automatic logic [3:0] rcr_next_flags(
    input logic [3:0] f,
    input rcr_pkg::rcr_events_t e,
    input logic pin,
    input logic sleeping
  );
    logic [3:0] n;
    n = f;
    if (e.wdt_timeout && !sleeping) begin
      n[`RCR_BIT_POWER_UP - `RCR_FLAGS_LSB] = 1'b0;
      n[`RCR_BIT_SLEEP_RECOVERY - `RCR_FLAGS_LSB] = 1'b0;
      n[`RCR_BIT_WATCHDOG - `RCR_FLAGS_LSB] = 1'b1;
    end
    if (pin) begin
      n[`RCR_BIT_PIN_RESET - `RCR_FLAGS_LSB] = 1'b1;
    end
    if (e.gpio_wake && sleeping) begin
      n = `RCR_FLAGS_GPIO_WAKE;
    end
    if (e.wdt_timeout && sleeping) begin
      n = `RCR_FLAGS_WDT_WAKE;
    end
    if (e.debug_wake && sleeping) begin
      n = `RCR_FLAGS_POWER;
    end
    if (e.power_on || e.brownout || e.debugger_reset) begin
      n = `RCR_FLAGS_POWER;
    end
    return n;
  endfunction

  // ****************************************************************
  // Reset pin sensing
  // ****************************************************************
  logic pin_event;
  logic pin_drive_q;
  logic pin_drive_d;

  // The filter pulses once per low period, so a pin held low for a long
  // time starts one reset and not a train of them.
  rcr_pin_filter #(
    .FILTER_CYCLES(PIN_FILTER_CYCLES)
  ) u_pin_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_n(reset_pin_n_in),
    .ignore(pin_drive_q),
    .assert_pulse(pin_event)
  );

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  rcr_pkg::rcr_state_t state_q;
  rcr_pkg::rcr_state_t state_d;
  logic [HW-1:0] hold_q;
  logic [HW-1:0] hold_d;

  wire wake_any = gpio_wake_ok || debug_wake_ok || wdt_wake;
  wire int_source = power_like || events.wdt_timeout || wake_any;
  wire any_source = int_source || pin_event;
  wire hold_done = (hold_q == HW'(1));

  // Every new source reloads the hold count, so a burst of causes keeps
  // the device in reset until the last of them has run its full time.
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    if (int_source) begin
      state_d = rcr_pkg::RCR_HOLD_INT;
      hold_d = HW'(RESET_HOLD_CYCLES);
    end else if (pin_event) begin
      if (state_q == rcr_pkg::RCR_IDLE) begin
        state_d = rcr_pkg::RCR_HOLD_EXT;
      end
      hold_d = HW'(RESET_HOLD_CYCLES);
    end else begin
      unique case (state_q)
        rcr_pkg::RCR_IDLE: begin
          hold_d = '0;
        end
        rcr_pkg::RCR_HOLD_INT, rcr_pkg::RCR_HOLD_EXT: begin
          hold_d = hold_q - 1'b1;
          if (hold_done) begin
            state_d = rcr_pkg::RCR_IDLE;
          end
        end
        default: begin
          state_d = rcr_pkg::RCR_IDLE;
          hold_d = '0;
        end
      endcase
    end
  end

  // The pin is driven only for causes raised inside the device; an outside
  // reset already holds it low, and driving it then would latch forever.
  assign pin_drive_d = (state_d == rcr_pkg::RCR_HOLD_INT);
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe = pin_drive_q;
  assign sys_reset_out = (state_q != rcr_pkg::RCR_IDLE);

  // Reset itself counts as an internal cause, so the pin is pulled low
  // and the hold is timed from release just as after a power-on event.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= rcr_pkg::RCR_HOLD_INT;
      hold_q <= HW'(RESET_HOLD_CYCLES);
      pin_drive_q <= 1'b1;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      pin_drive_q <= pin_drive_d;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic ack_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [`RCR_IRQ_W-1:0] irq_status_q;
  logic [`RCR_IRQ_W-1:0] irq_status_d;
  logic [`RCR_IRQ_W-1:0] irq_mask_q;
  logic [`RCR_IRQ_W-1:0] irq_mask_d;

  wire access = psel && penable;
  wire xfer = access && ack_q;
  // The answer is loaded in the first access cycle and handed over in the
  // second, which keeps read data on a flop at the price of a wait state.
  wire setup_done = access && !ack_q;
  wire hit_cause = (paddr == `RCR_OFS_CAUSE);
  wire hit_status = (paddr == `RCR_OFS_IRQ_STATUS);
  wire hit_mask = (paddr == `RCR_OFS_IRQ_MASK);
  wire hit_any = hit_cause || hit_status || hit_mask;
  wire cause_read = xfer && !pwrite && hit_cause;
  wire status_write = xfer && pwrite && hit_status;
  wire mask_write = xfer && pwrite && hit_mask;

  // The cause register is read-only; writes to it, reserved bits included,
  // are accepted without effect.
  wire [31:0] cause_word = {24'h000000, flags_q, 4'h0};
  wire [31:0] rdata =
    hit_cause ? cause_word :
    hit_status ? {25'h0000000, irq_status_q} :
    hit_mask ? {25'h0000000, irq_mask_q} : 32'h00000000;

  // One wait state lets read data come from a flop.
  assign pready = ack_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      ack_q <= setup_done;
      if (setup_done) begin
        prdata_q <= pwrite ? 32'h00000000 : rdata;
        pslverr_q <= !hit_any;
      end
    end
  end

  // ****************************************************************
  // Cause flags
  // ****************************************************************

  // The read value was captured a cycle earlier, so clearing at the
  // completing edge returns the flags before they drop. A source arriving
  // in that same cycle is applied after the clear and so survives.
  assign flags_d = rcr_next_flags(cause_read ? 4'h0 : flags_q,
    events, pin_event, in_sleep);

  // A pin reset only adds its own flag and keeps the causes already held,
  // so software may find the pin flag beside a watchdog flag.
  // Power-on is what the async reset models, so the flags wake up with the
  // power-on pattern and are otherwise untouched by the resets they record.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_q <= `RCR_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  wire [`RCR_IRQ_W-1:0] irq_events = {
    pin_event,
    events.debugger_reset,
    events.debug_wake && in_sleep,
    events.gpio_wake && in_sleep,
    events.wdt_timeout,
    events.brownout,
    events.power_on
  };
  // A source in the cycle of a one-to-clear write still sets its bit, so
  // an event is never lost to a clear that raced it.
  wire [`RCR_IRQ_W-1:0] w1c =
    status_write ? pwdata[`RCR_IRQ_W-1:0] : `RCR_IRQ_RESET;

  // Software should read the cause register before clearing the watchdog
  // bit here, or the cause may already have been overwritten.
  assign irq_status_d = (irq_status_q & ~w1c) | irq_events;
  assign irq_mask_d = mask_write ? pwdata[`RCR_IRQ_W-1:0] : irq_mask_q;
  assign irq = |(irq_status_q & irq_mask_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= `RCR_IRQ_RESET;
      irq_mask_q <= `RCR_IRQ_RESET;
    end else begin
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
    end
  end

endmodule
`default_nettype wire

/* File: tb/rcr_top_asserts.sv */
// Port checks of the reset cause recorder.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_regs.svh"
module rcr_top_asserts #(
  parameter int RESET_HOLD_CYCLES = 2,
  parameter int PIN_FILTER_CYCLES = 1
) (
  // Clock, reset and APB
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources and results
  input wire rcr_pkg::rcr_events_t events,
  input wire logic in_sleep,
  input wire logic reset_pin_n_in,
  input wire logic reset_pin_n_out,
  input wire logic reset_pin_n_oe,
  input wire logic sys_reset_out,
  input wire logic irq
);
  logic [7:0] hold_q;
  logic pin_q;
  wire logic done = psel && penable && pready;
  wire logic rd_c = done && !pwrite && paddr == `RCR_OFS_CAUSE;
  wire logic quiet = events == 6'h00;
  wire logic src = events.power_on || events.brownout ||
    events.wdt_timeout || events.debugger_reset ||
    (in_sleep && (events.gpio_wake || events.debug_wake));
  // A pin-started hold has no visible start, so it skips the length check.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_q <= 8'h01;
      pin_q <= 1'b0;
    end else begin
      hold_q <= src ? 8'h01 : hold_q + 8'h01;
      pin_q <= !src && (pin_q || (!reset_pin_n_in && !reset_pin_n_oe));
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_src; src |=> sys_reset_out && reset_pin_n_oe; endproperty
  a_src: assert property (p_src) else $error("no reset");
  property p_low; reset_pin_n_oe |-> !reset_pin_n_out; endproperty
  a_low: assert property (p_low) else $error("pin not low");
  property p_quiet;
    $rose(sys_reset_out) && !$past(src) |-> !reset_pin_n_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin driven");
  property p_oe; reset_pin_n_oe |-> sys_reset_out; endproperty
  a_oe: assert property (p_oe) else $error("drive outside reset");
  property p_hold;
    $fell(sys_reset_out) && !pin_q |-> hold_q == 8'(RESET_HOLD_CYCLES + 1);
  endproperty
  a_hold: assert property (p_hold) else $error("hold length");
  property p_rsv; rd_c |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_clr;
    rd_c && quiet ##1 (quiet && reset_pin_n_in)[*3] ##1 rd_c
      |-> prdata[7:4] == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_w1c;
    done && pwrite && paddr == `RCR_OFS_IRQ_STATUS && pwdata[6:0] == 7'h7f
      && quiet ##1 quiet[*2] |-> !irq;
  endproperty
  a_w1c: assert property (p_w1c) else $error("irq not cleared");
  cover property (rd_c && prdata[7:4] != 4'h0);
  cover property ($rose(sys_reset_out) && !reset_pin_n_oe);
  cover property ($rose(irq));
endmodule
bind rcr_top rcr_top_asserts #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
  .PIN_FILTER_CYCLES(PIN_FILTER_CYCLES)) chk_u (.sys_clk(sys_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .events(events), .in_sleep(in_sleep),
  .reset_pin_n_in(reset_pin_n_in), .reset_pin_n_out(reset_pin_n_out),
  .reset_pin_n_oe(reset_pin_n_oe), .sys_reset_out(sys_reset_out),
  .irq(irq));
`default_nettype wire

/* File: tb/rcr_top_test.sv */
// Directed testbench of the reset cause recorder.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_regs.svh"
module rcr_top_test;
  localparam int HOLD = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic in_sleep = 1'b0;
  logic drv_n = 1'b1;
  logic [`RCR_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, out_n, oe, sys_reset_out, irq, er;
  rcr_pkg::rcr_events_t events = 6'h00;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // The pin has a pull-up, so a released pin reads high.
  wire logic pin_n = (oe && !out_n) ? 1'b0 : drv_n;
  rcr_top #(.RESET_HOLD_CYCLES(HOLD), .PIN_FILTER_CYCLES(2)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events),
    .in_sleep(in_sleep), .reset_pin_n_in(pin_n), .reset_pin_n_out(out_n),
    .reset_pin_n_oe(oe), .sys_reset_out(sys_reset_out), .irq(irq));
  // **********
  // Helpers
  // **********
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    chk("apb wait", 32'h2, n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] e);
    apb(1'b0, `RCR_OFS_CAUSE, 32'h0);
    chk("cause", {24'h0, e}, rd);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (sys_reset_out !== v && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    #1;
    chk("reset", {31'h0, v}, {31'h0, sys_reset_out});
  endtask
  task automatic pulse(input logic [5:0] ev, input logic s);
    @(posedge sys_clk);
    events <= ev;
    in_sleep <= s;
    @(posedge sys_clk);
    events <= 6'h00;
    #1;
  endtask
  task automatic seq(input logic [5:0] a, input logic sa,
    input logic [5:0] b, input logic sb, input logic [7:0] f);
    pulse(a, sa);
    wait_rst(1'b0);
    pulse(b, sb);
    wait_rst(1'b0);
    rc(f);
  endtask
  task automatic pin_hit();
    @(posedge sys_clk);
    drv_n <= 1'b0;
    wait_rst(1'b1);
    chk("oe", 32'h0, {31'h0, oe});
    @(posedge sys_clk);
    drv_n <= 1'b1;
    wait_rst(1'b0);
  endtask
  // **********
  // Scenarios
  // **********
  task automatic t_power();
    wait_rst(1'b0);
    rc(8'h80);
    rc(8'h00);
  endtask
  task automatic t_table();
    logic [5:0] ev [8] = '{6'h20, 6'h10, 6'h01, 6'h02, 6'h04, 6'h08,
      6'h04, 6'h08};
    logic [3:0] fl [8] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h4, 4'h6, 4'h0, 4'h2};
    logic [7:0] sl = 8'h38;
    for (int i = 0; i < 8; i++) begin
      pulse(ev[i], sl[i]);
      chk("oe", {31'h0, fl[i] != 4'h0}, {31'h0, oe});
      wait_rst(1'b0);
      rc({fl[i], 4'h0});
    end
  endtask
  task automatic t_order();
    seq(6'h20, 1'b0, 6'h08, 1'b0, 8'h20);
    seq(6'h04, 1'b1, 6'h08, 1'b0, 8'h20);
    seq(6'h04, 1'b1, 6'h08, 1'b1, 8'h60);
    seq(6'h08, 1'b0, 6'h04, 1'b1, 8'h40);
    seq(6'h08, 1'b1, 6'h20, 1'b0, 8'h80);
  endtask
  task automatic t_pin();
    pin_hit();
    rc(8'h10);
    pin_hit();
    pulse(6'h04, 1'b1);
    wait_rst(1'b0);
    rc(8'h40);
  endtask
  task automatic t_irq();
    apb(1'b1, `RCR_OFS_IRQ_STATUS, 32'h7f);
    apb(1'b1, `RCR_OFS_IRQ_MASK, 32'h7f);
    pulse(6'h08, 1'b0);
    wait_rst(1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    rc(8'h20);
    apb(1'b0, `RCR_OFS_IRQ_STATUS, 32'h0);
    chk("status", 32'h4, rd);
    apb(1'b1, `RCR_OFS_IRQ_STATUS, 32'h7f);
    @(posedge sys_clk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `RCR_OFS_IRQ_MASK, 32'h0);
    pulse(6'h20, 1'b0);
    wait_rst(1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, `RCR_OFS_IRQ_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b1, `RCR_OFS_CAUSE, 32'hf0);
    rc(8'h80);
    apb(1'b0, 12'h100, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    chk("rdata", 32'h0, rd);
  endtask
  task automatic t_rst();
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("oe", 32'h1, {31'h0, oe});
    chk("reset", 32'h1, {31'h0, sys_reset_out});
    @(posedge sys_clk);
    rst <= 1'b0;
    wait_rst(1'b0);
    rc(8'h80);
    apb(1'b0, `RCR_OFS_IRQ_STATUS, 32'h0);
    chk("status", 32'h0, rd);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_power();
    t_table();
    t_order();
    t_pin();
    t_rst();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
